// ### serial_iface_pkg.sv
// Package of register map, field positions and mode codes for the serial interface control
`default_nettype none
package serial_iface_pkg;
    // Register indices; the bus sees one aligned word per index
    localparam logic [7:0] CTRL_INDEX = 8'h2A;
    localparam logic [7:0] STATUS_INDEX = 8'h2B;
    localparam logic [7:0] CTRL_OFFSET = 8'(CTRL_INDEX * 4);
    localparam logic [7:0] STATUS_OFFSET = 8'(STATUS_INDEX * 4);
    localparam logic [7:0] PORT_OFFSET = 8'h30;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam int START_IE_BIT = 7;
    localparam int OVF_IE_BIT = 6;
    localparam int WM_HI_BIT = 5;
    localparam int WM_LO_BIT = 4;
    localparam int CS_HI_BIT = 3;
    localparam int CS_LO_BIT = 2;
    localparam int STROBE_BIT = 1;
    localparam int TOGGLE_BIT = 0;
    localparam int START_FLAG_BIT = 7;
    localparam int OVF_FLAG_BIT = 6;
    localparam int DO_BIT = 0;
    localparam int DI_BIT = 1;
    localparam int SCK_BIT = 2;
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### serial_iface_wire_mode_control.sv
// Wire-mode output control, start and overflow flags and interrupt requests
`default_nettype none
// What this block does
// RL1: Start-condition enable set means start flag requests an interrupt.
// RL2: A pending start flag interrupts immediately once enable and global enable are set.
// RL3: Overflow enable set means overflow flag requests an interrupt.
// RL4: A pending overflow flag interrupts immediately once enable and global enable are set.
// RL5: Wire mode field alters only output drivers, never input function.
// RL6: Inputs are sampled and external clocking counts in every mode.
// RL7: Mode 00 disables outputs, hold and start detector; pins act as ports.
// RL8: Three-wire mode puts serial data on data-out pin; direction bit still gates.
// RL9: Three-wire input data-out pin takes pull-up from its port bit.
// RL10: Three-wire mode leaves data-in and clock pins as ordinary ports.
// RL11: Software makes master clock by toggling clock port bit, maybe via toggle strobe.
// RL12: Two-wire pins are open-drain, driver enabled only by direction bit one.
// RL13: Enabled data driver pulls low if data bit or port bit is zero.
// RL14: Enabled clock driver pulls low if port bit zero or hold requested.
// RL15: Two-wire start condition seen while clock direction bit is one holds clock low until start flag cleared.
// RL16: Two-wire modes disable pull-ups on data and clock pins.
// RL17: Mode 11 also holds clock low after overflow until overflow flag cleared.
// RL18: Control resets to zero; strobe and toggle bits write-only, read zero.
// RL19: Two-wire reuses data-in pin as data line and clock pin as clock line.
// RL20: Start flag sets on start condition in two-wire, any clock edge in three-wire mode.
// RL21: Overflow flag sets on counter wrap 15 to 0, cleared by writing one.
module serial_iface_wire_mode_control #(
    parameter int PORT_WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic globalIrqEnable,
    input wire logic [PORT_WIDTH-1:0] port_direction_bits,
    input wire logic dataRegMsb,
    input wire logic [3:0] counterValue,
    input wire logic counterStep,
    input wire logic dataOutPinIn,
    input wire logic serial_data_in_pin,
    input wire logic serial_clock_pin,
    output logic dataOutPinOut,
    output logic dataOutPinOe,
    output logic dataOutPullup,
    output logic sdaOut,
    output logic sdaOe,
    output logic sdaPullup,
    output logic sclOut,
    output logic sclOe,
    output logic sclPullup,
    output logic sampledData,
    output logic sampledClock,
    output logic clockEdge,
    output logic [1:0] clockSelect,
    output logic strobePulse,
    output logic startIrq,
    output logic overflowIrq
);
    logic [7:0] ctrl_reg;
    logic [PORT_WIDTH-1:0] port_output_bits;
    logic start_cond_flag;
    logic overflowFlag;
    logic holdStart;
    logic holdOverflow;
    logic [1:0] sdaSync;
    logic [1:0] sclSync;
    logic sclLast;
    logic sdaLast;
    logic [3:0] cntLast;
    logic cntStepLast;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wrFire;
    logic wrCtrl;
    logic wrStatus;
    logic wrPort;
    logic [1:0] wireMode;
    logic twoWire;
    logic startSeen;
    logic anyClkEdge;
    logic wrapSeen;
    logic startSet;
    logic ovfSet;
    localparam logic [PORT_WIDTH-1:0] PORT_RESET_W = '0;

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == serial_iface_pkg::CTRL_OFFSET) ||
                    (addr == serial_iface_pkg::STATUS_OFFSET) ||
                    (addr == serial_iface_pkg::PORT_OFFSET);
    endfunction

    assign wireMode = ctrl_reg[serial_iface_pkg::WM_HI_BIT:serial_iface_pkg::WM_LO_BIT];
    assign twoWire = wireMode[1]; // RL19
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    assign wrCtrl = wrFire && wStrb[0] && (awAddr == serial_iface_pkg::CTRL_OFFSET);
    assign wrStatus = wrFire && wStrb[0] && (awAddr == serial_iface_pkg::STATUS_OFFSET);
    assign wrPort = wrFire && wStrb[0] && (awAddr == serial_iface_pkg::PORT_OFFSET);
    // Inputs read only after the second sync stage
    assign startSeen = twoWire && sclSync[1] && sclLast && sdaLast && !sdaSync[1]; // RL20
    assign anyClkEdge = (wireMode != serial_iface_pkg::WM_OFF) && !twoWire &&
                        (sclSync[1] != sclLast); // RL20
    assign wrapSeen = counterStep && !cntStepLast && (cntLast == 4'hF) &&
                      (counterValue == 4'h0); // RL21
    assign startSet = startSeen || anyClkEdge;
    assign ovfSet = wrapSeen;

    // Two-stage synchronisers for the pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaSync <= 2'h3;
            sclSync <= 2'h3;
            sdaLast <= 1'b1;
            sclLast <= 1'b1;
        end else begin
            sdaSync <= {sdaSync[0], serial_data_in_pin};
            sclSync <= {sclSync[0], serial_clock_pin};
            sdaLast <= sdaSync[1];
            sclLast <= sclSync[1];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cntLast <= 4'h0;
            cntStepLast <= 1'b0;
        end else begin
            cntLast <= counterValue;
            cntStepLast <= counterStep;
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= serial_iface_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(awAddr) ? serial_iface_pkg::AXI_OKAY :
                               serial_iface_pkg::AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;

    // Control register; strobe bits are never stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= serial_iface_pkg::CTRL_RESET; // RL18
            strobePulse <= 1'b0;
        end else begin
            strobePulse <= wrCtrl && wData[serial_iface_pkg::STROBE_BIT];
            if (wrCtrl) begin
                ctrl_reg <= {wData[7:2], 2'h0}; // RL18
            end
        end
    end

    // Port output bits; toggle strobe flips the clock bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_output_bits <= PORT_RESET_W;
        end else if (wrPort) begin
            port_output_bits <= wData[PORT_WIDTH-1:0];
        end else if (wrCtrl && wData[serial_iface_pkg::TOGGLE_BIT]) begin
            port_output_bits[serial_iface_pkg::SCK_BIT] <=
                !port_output_bits[serial_iface_pkg::SCK_BIT]; // RL11
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_cond_flag <= 1'b0;
            overflowFlag <= 1'b0;
        end else begin
            if (startSet) begin
                start_cond_flag <= 1'b1; // RL20
            end else if (wrStatus && wData[serial_iface_pkg::START_FLAG_BIT]) begin
                start_cond_flag <= 1'b0;
            end
            if (ovfSet) begin
                overflowFlag <= 1'b1; // RL21
            end else if (wrStatus && wData[serial_iface_pkg::OVF_FLAG_BIT]) begin
                overflowFlag <= 1'b0; // RL21
            end
        end
    end

    // Clock holds; mode 00 never holds
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdStart <= 1'b0;
            holdOverflow <= 1'b0;
        end else begin
            if (twoWire && startSeen && port_direction_bits[serial_iface_pkg::SCK_BIT]) begin
                holdStart <= 1'b1; // RL15
            end else if (!start_cond_flag || !twoWire) begin
                holdStart <= 1'b0; // RL15
            end
            if (wireMode == serial_iface_pkg::WM_TWO_HOLD && ovfSet) begin
                holdOverflow <= 1'b1; // RL17
            end else if (!overflowFlag) begin
                holdOverflow <= 1'b0; // RL17
            end
        end
    end

    // Level interrupts, so a flag pending at enable fires at once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            startIrq <= 1'b0;
            overflowIrq <= 1'b0;
        end else begin
            startIrq <= start_cond_flag && ctrl_reg[serial_iface_pkg::START_IE_BIT] &&
                        globalIrqEnable; // RL1 RL2
            overflowIrq <= overflowFlag && ctrl_reg[serial_iface_pkg::OVF_IE_BIT] &&
                           globalIrqEnable; // RL3 RL4
        end
    end

    // Pin drivers; only the output side depends on mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOutPinOut <= 1'b0;
            dataOutPinOe <= 1'b0;
            dataOutPullup <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            sdaPullup <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
            sclPullup <= 1'b0;
        end else begin
            dataOutPinOe <= port_direction_bits[serial_iface_pkg::DO_BIT]; // RL8
            dataOutPullup <= !port_direction_bits[serial_iface_pkg::DO_BIT] &&
                             port_output_bits[serial_iface_pkg::DO_BIT]; // RL9
            dataOutPinOut <= (wireMode == serial_iface_pkg::WM_THREE) ? dataRegMsb :
                             port_output_bits[serial_iface_pkg::DO_BIT]; // RL7 RL8
            if (twoWire) begin
                sdaOut <= 1'b0; // RL12
                sdaOe <= port_direction_bits[serial_iface_pkg::DI_BIT] &&
                         (!dataRegMsb || !port_output_bits[serial_iface_pkg::DI_BIT]); // RL13
                sclOut <= 1'b0;
                sclOe <= port_direction_bits[serial_iface_pkg::SCK_BIT] &&
                         (!port_output_bits[serial_iface_pkg::SCK_BIT] ||
                          holdStart || (holdOverflow &&
                          wireMode == serial_iface_pkg::WM_TWO_HOLD)); // RL14 RL17
                sdaPullup <= 1'b0; // RL16
                sclPullup <= 1'b0; // RL16
            end else begin
                // Ordinary port pins in modes 00 and 01
                sdaOut <= port_output_bits[serial_iface_pkg::DI_BIT]; // RL7 RL10
                sdaOe <= port_direction_bits[serial_iface_pkg::DI_BIT];
                sdaPullup <= !port_direction_bits[serial_iface_pkg::DI_BIT] &&
                             port_output_bits[serial_iface_pkg::DI_BIT];
                sclOut <= port_output_bits[serial_iface_pkg::SCK_BIT]; // RL10
                sclOe <= port_direction_bits[serial_iface_pkg::SCK_BIT];
                sclPullup <= !port_direction_bits[serial_iface_pkg::SCK_BIT] &&
                             port_output_bits[serial_iface_pkg::SCK_BIT];
            end
        end
    end

    // Inputs keep their function whatever the mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sampledData <= 1'b1;
            sampledClock <= 1'b1;
            clockEdge <= 1'b0;
            clockSelect <= 2'h0;
        end else begin
            sampledData <= sdaSync[1]; // RL5 RL6
            sampledClock <= sclSync[1]; // RL6
            clockEdge <= sclSync[1] != sclLast; // RL6
            clockSelect <= ctrl_reg[serial_iface_pkg::CS_HI_BIT:serial_iface_pkg::CS_LO_BIT];
        end
    end

    // Read channel, one cycle after address
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= serial_iface_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= serial_iface_pkg::AXI_OKAY;
            if (s_axi_araddr == serial_iface_pkg::CTRL_OFFSET) begin
                s_axi_rdata <= {24'h000000, ctrl_reg}; // RL18
            end else if (s_axi_araddr == serial_iface_pkg::STATUS_OFFSET) begin
                s_axi_rdata <= {24'h000000, start_cond_flag, overflowFlag, 2'h0, counterValue};
            end else if (s_axi_araddr == serial_iface_pkg::PORT_OFFSET) begin
                s_axi_rdata <= 32'(port_output_bits);
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= serial_iface_pkg::AXI_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// ### serial_iface_wire_mode_control_sva.sv
// Checker of port relations for the serial interface wire-mode control
`default_nettype none
module serial_iface_wire_mode_control_sva #(
    parameter int PORT_WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic globalIrqEnable,
    input wire logic [PORT_WIDTH-1:0] port_direction_bits,
    input wire logic dataOutPinOe,
    input wire logic dataOutPullup,
    input wire logic sdaOe,
    input wire logic sdaPullup,
    input wire logic sclOe,
    input wire logic sclPullup,
    input wire logic startIrq,
    input wire logic overflowIrq
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_resp_a: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read response late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    sda_pull_off_a: assert property (!(sdaOe && sdaPullup))
        else $error("data pull-up while driven");
    scl_pull_off_a: assert property (!(sclOe && sclPullup))
        else $error("clock pull-up while driven");
    dout_pull_off_a: assert property (!(dataOutPinOe && dataOutPullup))
        else $error("data-out pull-up while driven");
    sda_dir_gate_a: assert property (sdaOe |-> $past(port_direction_bits[1]))
        else $error("data driver without direction");
    scl_dir_gate_a: assert property (sclOe |-> $past(port_direction_bits[2]))
        else $error("clock driver without direction");
    start_irq_gie_a: assert property (startIrq |-> $past(globalIrqEnable))
        else $error("start request without global enable");
    ovf_irq_gie_a: assert property (overflowIrq |-> $past(globalIrqEnable))
        else $error("overflow request without global enable");
endmodule
`default_nettype wire

// ### serial_bus_partner.sv
// Two-wire bus peer: opens frames, clocks bits, waits out clock holds
`default_nettype none
module serial_bus_partner (
    input wire logic sclLine,
    output logic sdaLow,
    output logic sclLow
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sdaLow = 1'b0;
        sclLow = 1'b0;
    end
    // Offset of 7 ns keeps pin moves off the block's clock edges
    task automatic startCond();
        #7;
        sdaLow = 1'b1;
        #100;
    endtask
    task automatic clockPulses(input int n);
        #7;
        repeat (n) begin
            sclLow = 1'b1;
            #100;
            sclLow = 1'b0;
            wait (sclLine);
            #100;
        end
    endtask
    task automatic stopCond();
        #7;
        sdaLow = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire

// ### serial_iface_wire_mode_control_test.sv
// Self-checking bench for the serial interface wire-mode control
`default_nettype none
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin nFail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module serial_iface_wire_mode_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst_n, globalIrqEnable, dataRegMsb, counterStep;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
    logic [3:0] s_axi_wstrb, counterValue;
    logic [1:0] s_axi_bresp, s_axi_rresp, clockSelect, rdResp;
    logic [2:0] port_direction_bits;
    logic dataOutPinIn, serial_data_in_pin, serial_clock_pin, dataOutPinOut, dataOutPinOe;
    logic dataOutPullup, sdaOut, sdaOe, sdaPullup, sclOut, sclOe, sclPullup, sdaLow, sclLow;
    logic sampledData, sampledClock, clockEdge, strobePulse, startIrq, overflowIrq;
    int nFail, cmpCount, nEdge, nStrobe, e0;
    // Mode, port, direction, data msb, then expected pin outputs
    logic [15:0] rows [9] = '{16'h3855, 16'h072A, 16'h41E0, 16'h4810, 16'h760A,
        16'hB680, 16'hB608, 16'h9682, 16'hF850};
    // Bus lines pulled up; whoever pulls low wins
    assign serial_data_in_pin = (sdaOe ? sdaOut : 1'b1) && !sdaLow;
    assign serial_clock_pin = (sclOe ? sclOut : 1'b1) && !sclLow;
    assign dataOutPinIn = dataOutPinOut;
    serial_iface_wire_mode_control i_dut (.*);
    serial_bus_partner i_partner (.sclLine(serial_clock_pin), .sdaLow(sdaLow), .sclLow(sclLow));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (clockEdge === 1'b1) nEdge++;
        if (strobePulse === 1'b1) nStrobe++;
    end
    task automatic printVerdict();
        if (nFail == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge ref_clk);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, serial_iface_pkg::AXI_OKAY)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        rdData = s_axi_rdata;
        rdResp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK(rdData, e)
    endtask
    task automatic wc(input logic [7:0] d);
        wr(serial_iface_pkg::CTRL_OFFSET, d);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic ws(input logic [7:0] d);
        wr(serial_iface_pkg::STATUS_OFFSET, d);
        repeat (4) @(posedge ref_clk);
    endtask
    initial begin
        {rst_n, globalIrqEnable, dataRegMsb, counterStep, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, counterValue} = '0;
        s_axi_wstrb = 4'hF;
        port_direction_bits = 3'h0;
        {nFail, cmpCount, nEdge, nStrobe} = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wc({2'h0, rows[i][15:14], 4'h0});
            wr(serial_iface_pkg::PORT_OFFSET, {5'h00, rows[i][13:11]});
            port_direction_bits <= rows[i][10:8];
            dataRegMsb <= rows[i][7];
            repeat (8) @(posedge ref_clk);
            ws(8'hC0);
            `CHK({dataOutPinOut, dataOutPinOe, dataOutPullup, sdaOe, sdaPullup, sclOe, sclPullup},
                rows[i][6:0])
        end
        wc(8'hFF);
        rd(serial_iface_pkg::CTRL_OFFSET, 32'h000000FC);
        rd(serial_iface_pkg::PORT_OFFSET, 32'h00000003);
        `CHK(clockSelect, 2'h3)
        `CHK(nStrobe, 1)
        rd(8'h3C, 32'h00000000);
        `CHK(rdResp, serial_iface_pkg::AXI_SLVERR)
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(serial_iface_pkg::CTRL_OFFSET, 32'h00000000);
        wr(serial_iface_pkg::PORT_OFFSET, 8'h06);
        port_direction_bits <= 3'h6;
        dataRegMsb <= 1'b1;
        globalIrqEnable <= 1'b1;
        wc(8'h70);
        counterValue <= 4'hF;
        @(posedge ref_clk);
        counterStep <= 1'b1;
        counterValue <= 4'h0;
        @(posedge ref_clk);
        counterStep <= 1'b0;
        repeat (6) @(posedge ref_clk);
        `CHK({overflowIrq, sclOe}, 2'h3)
        globalIrqEnable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK(overflowIrq, 1'b0)
        globalIrqEnable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(overflowIrq, 1'b1)
        wc(8'h60);
        `CHK(sclOe, 1'b0)
        wc(8'h70);
        `CHK(sclOe, 1'b1)
        ws(8'h40);
        `CHK({overflowIrq, sclOe}, 2'h0)
        wc(8'hA0);
        i_partner.startCond();
        repeat (8) @(posedge ref_clk);
        `CHK({startIrq, sclOe, sampledData}, 3'h6)
        `CHK(sampledClock, 1'b0)
        wc(8'h20);
        `CHK(startIrq, 1'b0)
        wc(8'hA0);
        `CHK(startIrq, 1'b1)
        ws(8'h80);
        `CHK({startIrq, sclOe}, 2'h0)
        i_partner.clockPulses(2);
        i_partner.stopCond();
        @(posedge ref_clk);
        port_direction_bits <= 3'h0;
        wc(8'h00);
        ws(8'hC0);
        e0 = nEdge;
        i_partner.clockPulses(2);
        repeat (6) @(posedge ref_clk);
        `CHK(nEdge - e0, 4)
        rd(serial_iface_pkg::STATUS_OFFSET, 32'h00000000);
        wc(8'h10);
        i_partner.clockPulses(1);
        repeat (6) @(posedge ref_clk);
        rd(serial_iface_pkg::STATUS_OFFSET, 32'h00000080);
        printVerdict();
    end
    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #200000;
        nFail++;
        printVerdict();
    end
endmodule
bind serial_iface_wire_mode_control serial_iface_wire_mode_control_sva #(
    .PORT_WIDTH(PORT_WIDTH)
) i_sva (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .globalIrqEnable,
    .port_direction_bits, .dataOutPinOe, .dataOutPullup, .sdaOe, .sdaPullup, .sclOe,
    .sclPullup, .startIrq, .overflowIrq);
`default_nettype wire
